// ===== verilog/lpmwc_consts.svh
`ifndef LPMWC_CONSTS_SVH
`define LPMWC_CONSTS_SVH

// Register byte offsets
`define LPMWC_OFF_SCC 8'h00
`define LPMWC_OFF_HS_OSC_CONTROL_REG 8'h04
`define LPMWC_OFF_PAWAKE 8'h08
`define LPMWC_OFF_PBWAKE 8'h0c
`define LPMWC_OFF_STATUS 8'h10
`define LPMWC_OFF_WDTCTL 8'h14

// Register bit fields
`define LPMWC_SCC_SEL_HI 7
`define LPMWC_SCC_SEL_LO 5
`define LPMWC_SCC_FKEEP 1
`define LPMWC_SCC_SKEEP 0
`define LPMWC_HS_OSC_CONTROL_REG_STABLE 1
`define LPMWC_HS_OSC_CONTROL_REG_EN 0
`define LPMWC_STAT_PDF 0
`define LPMWC_STAT_TO 1
`define LPMWC_STAT_MODE_LO 4
`define LPMWC_STAT_MODE_HI 6
`define LPMWC_WDTCTL_EN 0

// Reset values
`define LPMWC_SCC_RST 8'h00
`define LPMWC_HS_EN_RST 1'b1
`define LPMWC_WAKE_EN_RST 8'h00
`define LPMWC_WDT_EN_RST 1'b1

// Clock select code that picks the slow sub clock
`define LPMWC_SEL_SUB 3'h7

// Oscillator settling time and clock period, both in ns
`define LPMWC_CLK_PERIOD_NS 20
`define LPMWC_HS_SETTLE_NS 1000
`define LPMWC_HS_SETTLE_CYC \
   ((`LPMWC_HS_SETTLE_NS + `LPMWC_CLK_PERIOD_NS - 1) / `LPMWC_CLK_PERIOD_NS)

`endif

// ===== verilog/lpmwc_pkg.sv
package lpmwc_pkg;

   typedef enum logic [2:0] {
      LPMWC_ST_RUN = 3'b000,
      LPMWC_ST_SLEEP = 3'b001,
      LPMWC_ST_SLOW_ONLY_IDLE_MODE = 3'b010,
      LPMWC_ST_DUAL_CLOCK_IDLE_MODE = 3'b011,
      LPMWC_ST_FAST_ONLY_IDLE_MODE = 3'b100,
      LPMWC_ST_WAKE = 3'b101
   } lpmwc_state_t;

   // Clock gates, sub clock select and divider handed to the clock tree
   typedef struct packed {
      logic fast_on;
      logic sub_on;
      logic low_speed_rc_osc_on;
      logic cpu_on;
      logic sys_from_sub;
      logic [2:0] div_log2;
   } lpmwc_clk_ctl_t;

   typedef struct packed {
      logic wdt;
      logic irq;
      logic pin;
   } lpmwc_cause_t;

endpackage : lpmwc_pkg

// ===== verilog/lpmwc_top.sv
`timescale 1ns/100ps
`include "lpmwc_consts.svh"

module lpmwc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic halt_instr_i,
   input wire logic clear_watchdog_instr_i,
   input wire logic [7:0] port_a_i,
   input wire logic [7:0] port_b_i,
   input wire logic [7:0] irq_req_i,
   input wire logic [7:0] irq_en_i,
   input wire logic stack_full_i,
   input wire logic wdt_overflow_i,
   output lpmwc_pkg::lpmwc_clk_ctl_t clk_ctl_o,
   output logic freeze_o,
   output logic powered_down_flag_o,
   output logic watchdog_timeout_flag_o,
   output logic hs_osc_stable_flag_o,
   output logic wdt_clear_o,
   output logic wdt_run_o,
   output logic resume_next_o,
   output logic irq_service_o,
   output logic pc_sp_reset_o,
   output logic [2:0] lp_mode_o
);

   localparam logic [7:0] SETTLE_CYC = 8'(`LPMWC_HS_SETTLE_CYC);
   localparam logic [7:0] SCC_RST = `LPMWC_SCC_RST;

   lpmwc_pkg::lpmwc_state_t state_reg;
   lpmwc_pkg::lpmwc_state_t state_next;
   lpmwc_pkg::lpmwc_cause_t cause_reg;
   lpmwc_pkg::lpmwc_cause_t cause_now;
   lpmwc_pkg::lpmwc_clk_ctl_t clk_next;
   logic [2:0] sys_clk_select_reg;
   logic fast_osc_keep_on_halt_reg;
   logic slow_osc_keep_on_halt_reg;
   logic hs_osc_enable_reg;
   logic [7:0] port_a_wake_enable_reg;
   logic [7:0] port_b_wake_enable_reg;
   logic wdt_enable_reg;
   logic [7:0] port_a_prev_reg;
   logic [7:0] port_b_prev_reg;
   logic [7:0] irq_armed_reg;
   logic [7:0] irq_woke_reg;
   logic fast_on_reg;
   logic [7:0] settle_cnt_reg;
   logic halt_go;
   logic low_power;
   logic wake_any;
   logic bus_req;
   logic fast_needed;
   logic [3:0] clk_code;

   function automatic logic [3:0] clk_decode(input logic [2:0] sel);
      // Returns {from_sub, log2 of divide}
      if (sel == `LPMWC_SEL_SUB) begin
         clk_decode = 4'h8;
      end else begin
         clk_decode = {1'b0, sel};
      end
   endfunction : clk_decode

   assign halt_go = (state_reg == lpmwc_pkg::LPMWC_ST_RUN) && halt_instr_i;
   assign low_power = (state_reg != lpmwc_pkg::LPMWC_ST_RUN)
                      && (state_reg != lpmwc_pkg::LPMWC_ST_WAKE);
   assign bus_req = cyc_i && stb_i && !ack_o;
   assign fast_needed = (sys_clk_select_reg != `LPMWC_SEL_SUB);
   assign clk_code = clk_decode(sys_clk_select_reg);

   always_comb begin
      cause_now.pin = |((port_a_prev_reg & ~port_a_i) & port_a_wake_enable_reg)
                      | |((port_b_prev_reg & ~port_b_i) & port_b_wake_enable_reg);
      cause_now.irq = |(irq_req_i & irq_armed_reg);
      cause_now.wdt = wdt_overflow_i && wdt_enable_reg;
   end
   assign wake_any = low_power && (|cause_now);

   // Mode selection on halt and wake
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         lpmwc_pkg::LPMWC_ST_RUN: begin
            if (halt_instr_i) begin
               unique case ({fast_osc_keep_on_halt_reg, slow_osc_keep_on_halt_reg})
                  2'b00: state_next = lpmwc_pkg::LPMWC_ST_SLEEP;
                  2'b01: state_next = lpmwc_pkg::LPMWC_ST_SLOW_ONLY_IDLE_MODE;
                  2'b11: state_next = lpmwc_pkg::LPMWC_ST_DUAL_CLOCK_IDLE_MODE;
                  2'b10: state_next = lpmwc_pkg::LPMWC_ST_FAST_ONLY_IDLE_MODE;
               endcase
            end
         end
         lpmwc_pkg::LPMWC_ST_SLEEP, lpmwc_pkg::LPMWC_ST_SLOW_ONLY_IDLE_MODE,
         lpmwc_pkg::LPMWC_ST_DUAL_CLOCK_IDLE_MODE, lpmwc_pkg::LPMWC_ST_FAST_ONLY_IDLE_MODE: begin
            if (wake_any) begin
               state_next = lpmwc_pkg::LPMWC_ST_WAKE;
            end
         end
         lpmwc_pkg::LPMWC_ST_WAKE: begin
            if (!fast_needed || hs_osc_stable_flag_o) begin
               state_next = lpmwc_pkg::LPMWC_ST_RUN;
            end
         end
         default: state_next = lpmwc_pkg::LPMWC_ST_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= lpmwc_pkg::LPMWC_ST_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // Clock gating follows the next state so outputs align with state_reg
   always_comb begin
      clk_next.sys_from_sub = clk_code[3];
      clk_next.div_log2 = clk_code[2:0];
      clk_next.cpu_on = 1'b0;
      clk_next.fast_on = hs_osc_enable_reg || fast_needed;
      clk_next.sub_on = 1'b1;
      // sub clock needs the RC oscillator
      clk_next.low_speed_rc_osc_on = 1'b1;
      unique case (state_next)
         lpmwc_pkg::LPMWC_ST_RUN: clk_next.cpu_on = 1'b1;
         lpmwc_pkg::LPMWC_ST_SLEEP: begin
            clk_next.fast_on = 1'b0;
            clk_next.sub_on = 1'b0;
            clk_next.low_speed_rc_osc_on = wdt_enable_reg;
         end
         lpmwc_pkg::LPMWC_ST_SLOW_ONLY_IDLE_MODE: clk_next.fast_on = 1'b0;
         lpmwc_pkg::LPMWC_ST_DUAL_CLOCK_IDLE_MODE: clk_next.fast_on = 1'b1;
         lpmwc_pkg::LPMWC_ST_FAST_ONLY_IDLE_MODE: begin
            clk_next.fast_on = 1'b1;
            clk_next.sub_on = 1'b0;
            clk_next.low_speed_rc_osc_on = wdt_enable_reg;
         end
         lpmwc_pkg::LPMWC_ST_WAKE: clk_next.fast_on = clk_next.fast_on;
         default: clk_next.fast_on = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_ctl_o <= '0;
         freeze_o <= 1'b0;
         lp_mode_o <= 3'h0;
         fast_on_reg <= 1'b0;
      end else begin
         clk_ctl_o <= clk_next;
         fast_on_reg <= clk_next.fast_on;
         lp_mode_o <= state_next;
         freeze_o <= (state_next != lpmwc_pkg::LPMWC_ST_RUN);
      end
   end

   // stable flag drops on restart, rises after settling
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         settle_cnt_reg <= 8'h00;
         hs_osc_stable_flag_o <= 1'b0;
      end else if (clk_next.fast_on && !fast_on_reg) begin
         settle_cnt_reg <= 8'h00;
         hs_osc_stable_flag_o <= 1'b0;
      end else if (!clk_next.fast_on) begin
         settle_cnt_reg <= 8'h00;
         hs_osc_stable_flag_o <= 1'b0;
      end else if (settle_cnt_reg < SETTLE_CYC) begin
         settle_cnt_reg <= settle_cnt_reg + 8'h01;
      end else begin
         hs_osc_stable_flag_o <= 1'b1;
      end
   end

   // Wake inputs: pin history and interrupt arming
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_a_prev_reg <= 8'h00;
         port_b_prev_reg <= 8'h00;
         irq_armed_reg <= 8'h00;
      end else begin
         port_a_prev_reg <= port_a_i;
         port_b_prev_reg <= port_b_i;
         if (halt_go) begin
            irq_armed_reg <= ~irq_req_i;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cause_reg <= '0;
         irq_woke_reg <= 8'h00;
      end else if (wake_any) begin
         cause_reg <= cause_now;
         irq_woke_reg <= irq_req_i & irq_armed_reg;
      end
   end

   // Resume actions issued when the core clock returns
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         resume_next_o <= 1'b0;
         irq_service_o <= 1'b0;
         pc_sp_reset_o <= 1'b0;
      end else begin
         resume_next_o <= 1'b0;
         irq_service_o <= 1'b0;
         pc_sp_reset_o <= 1'b0;
         if ((state_reg == lpmwc_pkg::LPMWC_ST_WAKE)
             && (state_next == lpmwc_pkg::LPMWC_ST_RUN)) begin
            if (cause_reg.wdt) begin
               // only PC and stack pointer reset
               pc_sp_reset_o <= 1'b1;
            end else if (cause_reg.irq
                         && |(irq_woke_reg & irq_en_i) && !stack_full_i) begin
               irq_service_o <= 1'b1;
            end else begin
               resume_next_o <= 1'b1;
            end
         end
      end
   end

   // Status flags; a new event in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         powered_down_flag_o <= 1'b0;
         watchdog_timeout_flag_o <= 1'b0;
      end else begin
         // set by halt, cleared by instruction
         if (halt_go) begin
            powered_down_flag_o <= 1'b1;
         end else if (clear_watchdog_instr_i) begin
            powered_down_flag_o <= 1'b0;
         end
         if (wake_any && cause_now.wdt) begin
            watchdog_timeout_flag_o <= 1'b1;
         end else if (halt_go) begin
            watchdog_timeout_flag_o <= 1'b0;
         end
      end
   end

   // watchdog cleared on halt, runs only when enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wdt_clear_o <= 1'b0;
         wdt_run_o <= `LPMWC_WDT_EN_RST;
      end else begin
         wdt_clear_o <= halt_go || clear_watchdog_instr_i;
         wdt_run_o <= wdt_enable_reg;
      end
   end

   // Register writes; honoured in every state when byte lane 0 is selected
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sys_clk_select_reg <= SCC_RST[`LPMWC_SCC_SEL_HI:`LPMWC_SCC_SEL_LO];
         fast_osc_keep_on_halt_reg <= SCC_RST[`LPMWC_SCC_FKEEP];
         slow_osc_keep_on_halt_reg <= SCC_RST[`LPMWC_SCC_SKEEP];
         hs_osc_enable_reg <= `LPMWC_HS_EN_RST;
         port_a_wake_enable_reg <= `LPMWC_WAKE_EN_RST;
         port_b_wake_enable_reg <= `LPMWC_WAKE_EN_RST;
         wdt_enable_reg <= `LPMWC_WDT_EN_RST;
      end else if (bus_req && we_i && sel_i[0]) begin
         unique case (adr_i)
            `LPMWC_OFF_SCC: begin
               sys_clk_select_reg <= dat_i[`LPMWC_SCC_SEL_HI:`LPMWC_SCC_SEL_LO];
               fast_osc_keep_on_halt_reg <= dat_i[`LPMWC_SCC_FKEEP];
               slow_osc_keep_on_halt_reg <= dat_i[`LPMWC_SCC_SKEEP];
            end
            `LPMWC_OFF_HS_OSC_CONTROL_REG: hs_osc_enable_reg <= dat_i[`LPMWC_HS_OSC_CONTROL_REG_EN];
            `LPMWC_OFF_PAWAKE: port_a_wake_enable_reg <= dat_i[7:0];
            `LPMWC_OFF_PBWAKE: port_b_wake_enable_reg <= dat_i[7:0];
            `LPMWC_OFF_WDTCTL: wdt_enable_reg <= dat_i[`LPMWC_WDTCTL_EN];
            default: wdt_enable_reg <= wdt_enable_reg;
         endcase
      end
   end

   // Wishbone answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= bus_req;
         dat_o <= 32'h0000_0000;
         if (bus_req && !we_i) begin
            unique case (adr_i)
               `LPMWC_OFF_SCC: begin
                  dat_o[`LPMWC_SCC_SEL_HI:`LPMWC_SCC_SEL_LO] <= sys_clk_select_reg;
                  dat_o[`LPMWC_SCC_FKEEP] <= fast_osc_keep_on_halt_reg;
                  dat_o[`LPMWC_SCC_SKEEP] <= slow_osc_keep_on_halt_reg;
               end
               `LPMWC_OFF_HS_OSC_CONTROL_REG: begin
                  dat_o[`LPMWC_HS_OSC_CONTROL_REG_STABLE] <= hs_osc_stable_flag_o;
                  dat_o[`LPMWC_HS_OSC_CONTROL_REG_EN] <= hs_osc_enable_reg;
               end
               `LPMWC_OFF_PAWAKE: dat_o[7:0] <= port_a_wake_enable_reg;
               `LPMWC_OFF_PBWAKE: dat_o[7:0] <= port_b_wake_enable_reg;
               `LPMWC_OFF_STATUS: begin
                  dat_o[`LPMWC_STAT_PDF] <= powered_down_flag_o;
                  dat_o[`LPMWC_STAT_TO] <= watchdog_timeout_flag_o;
                  dat_o[`LPMWC_STAT_MODE_HI:`LPMWC_STAT_MODE_LO] <= lp_mode_o;
               end
               `LPMWC_OFF_WDTCTL: dat_o[`LPMWC_WDTCTL_EN] <= wdt_enable_reg;
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   localparam int WAKE_MAX = 60;

   a_halt_flags: assert property (halt_go |=> powered_down_flag_o && !watchdog_timeout_flag_o)
      else $error("halt did not set pd flag or clear timeout");
   a_halt_wdt_clear: assert property (halt_go |=> wdt_clear_o)
      else $error("halt did not clear the watchdog");
   a_sleep_clocks: assert property ((state_reg == lpmwc_pkg::LPMWC_ST_SLEEP)
      |-> !clk_ctl_o.cpu_on && !clk_ctl_o.fast_on && !clk_ctl_o.sub_on)
      else $error("clocks running in sleep");
   a_slow_only_idle_mode_clocks: assert property ((state_reg == lpmwc_pkg::LPMWC_ST_SLOW_ONLY_IDLE_MODE)
      |-> !clk_ctl_o.fast_on && clk_ctl_o.sub_on && !clk_ctl_o.cpu_on)
      else $error("slow-only idle clocks wrong");
   a_dual_clock_idle_mode_clocks: assert property ((state_reg == lpmwc_pkg::LPMWC_ST_DUAL_CLOCK_IDLE_MODE)
      |-> clk_ctl_o.fast_on && clk_ctl_o.sub_on && !clk_ctl_o.cpu_on)
      else $error("dual-clock idle clocks wrong");
   a_fast_only_idle_mode_clocks: assert property ((state_reg == lpmwc_pkg::LPMWC_ST_FAST_ONLY_IDLE_MODE)
      |-> clk_ctl_o.fast_on && !clk_ctl_o.sub_on && !clk_ctl_o.cpu_on)
      else $error("fast-only idle clocks wrong");
   a_freeze_held: assert property (low_power |-> freeze_o)
      else $error("state not frozen in low power");
   a_pdf_clear_cause: assert property ($fell(powered_down_flag_o)
      |-> $past(clear_watchdog_instr_i))
      else $error("pd flag cleared without instruction");
   a_wdt_wake_reset: assert property ((wake_any && cause_now.wdt)
      |=> watchdog_timeout_flag_o ##[1:WAKE_MAX] pc_sp_reset_o)
      else $error("watchdog wake did not reset pc and sp");
   a_stable_restart: assert property ($rose(fast_on_reg) |-> !hs_osc_stable_flag_o)
      else $error("stable flag high at oscillator restart");
   a_core_waits: assert property ($rose(clk_ctl_o.cpu_on) && fast_needed
      && $past(state_reg == lpmwc_pkg::LPMWC_ST_WAKE)
      |-> $past(hs_osc_stable_flag_o))
      else $error("core released before oscillator stable");

endmodule : lpmwc_top

// ===== testbench/lpmwc_core_model.sv
`timescale 1ns/100ps
module lpmwc_core_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic halt_req_i,
   input wire logic clr_req_i,
   input wire logic resume_next_i,
   input wire logic irq_service_i,
   input wire logic pc_sp_reset_i,
   output logic halt_instr_o,
   output logic clear_watchdog_instr_o,
   output logic [1:0] last_return_o
);
   // Instructions leave the core as one-cycle pulses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_instr_o <= 1'b0;
         clear_watchdog_instr_o <= 1'b0;
      end else begin
         halt_instr_o <= halt_req_i & ~halt_instr_o;
         clear_watchdog_instr_o <= clr_req_i & ~clear_watchdog_instr_o;
      end
   end

   // restart kind
   // A halt forgets the last restart so a missing pulse shows up
   always_ff @(posedge clk_i) begin
      if (rst_i || halt_instr_o) begin
         last_return_o <= 2'h0;
      end else if (pc_sp_reset_i) begin
         last_return_o <= 2'h3;
      end else if (irq_service_i) begin
         last_return_o <= 2'h2;
      end else if (resume_next_i) begin
         last_return_o <= 2'h1;
      end
   end
endmodule : lpmwc_core_model

// ===== testbench/low_power_mode_wake_control_test.sv
`timescale 1ns/100ps
`include "lpmwc_consts.svh"
module low_power_mode_wake_control_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic ack_o;
   logic halt_req = 1'b0;
   logic clr_req = 1'b0;
   logic halt_instr, clr_instr;
   logic [7:0] port_a_i = 8'hff;
   logic [7:0] port_b_i = 8'hff;
   logic [7:0] irq_req_i = 8'h00;
   logic [7:0] irq_en_i = 8'h00;
   logic stack_full_i = 1'b0;
   logic wdt_overflow_i = 1'b0;
   lpmwc_pkg::lpmwc_clk_ctl_t clk_ctl_o;
   logic freeze_o, pd_o, to_o, stable_o, wdt_clear_o, wdt_run_o;
   logic resume_next_o, irq_service_o, pc_sp_reset_o;
   logic [2:0] lp_mode_o;
   logic [1:0] last_ret;
   int miscompares = 0;
   int checks_done = 0;
   int exp_pd = 0;
   int exp_to = 0;
   int exp_ret = 0;
   int irq_ret[$] = '{2, 1, 1};
   logic [31:0] q;
   int k, b, pa;

   always #10 clk_i = ~clk_i;

   lpmwc_top lpmwc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
      .halt_instr_i(halt_instr), .clear_watchdog_instr_i(clr_instr), .port_a_i(port_a_i),
      .port_b_i(port_b_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
      .stack_full_i(stack_full_i), .wdt_overflow_i(wdt_overflow_i), .clk_ctl_o(clk_ctl_o),
      .freeze_o(freeze_o), .powered_down_flag_o(pd_o), .watchdog_timeout_flag_o(to_o),
      .hs_osc_stable_flag_o(stable_o), .wdt_clear_o(wdt_clear_o), .wdt_run_o(wdt_run_o),
      .resume_next_o(resume_next_o), .irq_service_o(irq_service_o),
      .pc_sp_reset_o(pc_sp_reset_o), .lp_mode_o(lp_mode_o));

   lpmwc_core_model lpmwc_core_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .halt_req_i(halt_req), .clr_req_i(clr_req), .resume_next_i(resume_next_o),
      .irq_service_i(irq_service_o), .pc_sp_reset_i(pc_sp_reset_o),
      .halt_instr_o(halt_instr), .clear_watchdog_instr_o(clr_instr),
      .last_return_o(last_ret));

   task automatic tally_and_finish;
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      adr_i <= a;
      we_i <= w;
      dat_i <= d;
      sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      chk("ack", 1, n < 50);
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb

   task automatic enter(input logic [1:0] keep);
      wb(8'h00, 1'b1, {30'h0, keep}, q);
      @(posedge clk_i) halt_req <= 1'b1;
      @(posedge clk_i) halt_req <= 1'b0;
      @(posedge clk_i) #1;
      exp_pd = 1;
      exp_to = 0;
      chk("mode", keep == 0 ? 1 : keep == 1 ? 2 : keep == 3 ? 3 : 4, lp_mode_o);
      chk("freeze", 1, freeze_o);
      chk("pd", exp_pd, pd_o);
      chk("timeout", exp_to, to_o);
      chk("wdt_clear", 1, wdt_clear_o);
      chk("fast_on", keep[1], clk_ctl_o.fast_on);
      chk("sub_on", keep[0], clk_ctl_o.sub_on);
      chk("cpu_on", 0, clk_ctl_o.cpu_on);
   endtask : enter

   task automatic wait_run(input logic fast_off);
      int n;
      n = 0;
      do begin
         @(posedge clk_i) #1;
         n++;
      end while (lp_mode_o !== 3'h0 && n < 300);
      chk("woken", 1, n < 300);
      chk("stable", 1, stable_o);
      if (fast_off) begin
         chk("settle", 1, n >= `LPMWC_HS_SETTLE_CYC - 1);
      end
      chk("cpu_on", 1, clk_ctl_o.cpu_on);
      @(posedge clk_i) #1;
      chk("return", exp_ret, last_ret);
      chk("pd", exp_pd, pd_o);
      chk("timeout", exp_to, to_o);
      chk("freeze", 0, freeze_o);
   endtask : wait_run

   task automatic stay(input logic [2:0] m);
      repeat (20) @(posedge clk_i);
      #1;
      chk("still", m, lp_mode_o);
   endtask : stay

   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      void'($urandom(32'hb2d16aba));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i) #1;
      chk("mode", 0, lp_mode_o);
      chk("pd", 0, pd_o);
      chk("wdt_run", 1, wdt_run_o);
      wb(8'h14, 1'b0, 32'h0, q);
      chk("wdtctl", 32'h1, q);
      wb(8'h3c, 1'b1, 32'hffff_ffff, q);
      wb(8'h3c, 1'b0, 32'h0, q);
      chk("unmapped", 32'h0, q);
      for (k = 0; k < 8; k++) begin
         wb(8'h00, 1'b1, k << 5, q);
         @(posedge clk_i) #1;
         chk("sys_from_sub", k == 7, clk_ctl_o.sys_from_sub);
         if (k < 7) begin
            chk("div", k, clk_ctl_o.div_log2);
         end
      end
      for (k = 0; k < 4; k++) begin
         b = $urandom_range(7, 0);
         pa = $urandom_range(1, 0);
         wb(pa ? 8'h0c : 8'h08, 1'b1, 32'h1 << b, q);
         enter(k[1:0]);
         if (k == 0) begin
            chk("low_speed_rc_osc_on", 1, clk_ctl_o.low_speed_rc_osc_on);
         end
         @(posedge clk_i);
         if (pa) begin
            port_a_i[b] <= 1'b0;
         end else begin
            port_b_i[b] <= 1'b0;
         end
         stay(k == 0 ? 1 : k == 1 ? 2 : k == 3 ? 3 : 4);
         if (pa) begin
            port_b_i[b] <= 1'b0;
         end else begin
            port_a_i[b] <= 1'b0;
         end
         exp_ret = 1;
         wait_run(!k[1]);
         port_a_i <= 8'hff;
         port_b_i <= 8'hff;
         wb(pa ? 8'h0c : 8'h08, 1'b1, 32'h0, q);
         if (k == 0) begin
            wb(8'h04, 1'b0, 32'h0, q);
            chk("hs_osc_control_reg", 32'h3, q);
         end
      end
      @(posedge clk_i) clr_req <= 1'b1;
      @(posedge clk_i) clr_req <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      exp_pd = 0;
      chk("pd", exp_pd, pd_o);
      for (k = 0; k < 3; k++) begin
         b = $urandom_range(7, 0);
         enter(2'b11);
         @(posedge clk_i);
         irq_req_i[b] <= 1'b1;
         irq_en_i[b] <= (k != 1);
         stack_full_i <= (k == 2);
         exp_ret = irq_ret[k];
         wait_run(1'b0);
         irq_req_i <= 8'h00;
         irq_en_i <= 8'h00;
         stack_full_i <= 1'b0;
      end
      irq_req_i[3] <= 1'b1;
      irq_en_i[3] <= 1'b1;
      enter(2'b00);
      stay(3'h1);
      wdt_overflow_i <= 1'b1;
      @(posedge clk_i) wdt_overflow_i <= 1'b0;
      exp_ret = 3;
      exp_to = 1;
      wait_run(1'b1);
      irq_req_i <= 8'h00;
      irq_en_i <= 8'h00;
      wb(8'h14, 1'b1, 32'h0, q);
      @(posedge clk_i) #1;
      chk("wdt_run", 0, wdt_run_o);
      enter(2'b00);
      chk("low_speed_rc_osc_off", 0, clk_ctl_o.low_speed_rc_osc_on);
      @(posedge clk_i) wdt_overflow_i <= 1'b1;
      @(posedge clk_i) wdt_overflow_i <= 1'b0;
      stay(3'h1);
      irq_req_i[5] <= 1'b1;
      irq_en_i[5] <= 1'b1;
      exp_ret = 2;
      wait_run(1'b1);
      irq_req_i <= 8'h00;
      irq_en_i <= 8'h00;
      wb(8'h14, 1'b1, 32'h1, q);
      tally_and_finish();
   end
endmodule : low_power_mode_wake_control_test
